// ===== include/crf_map.svh
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH

// Datapath widths of the register file.
`define CRF_WORD_W 16
`define CRF_ADDR_W 20
`define CRF_FLAG_W 11
`define CRF_LONG_W 32

// Register population: thirteen registers, seven of them switched by bank.
`define CRF_REG_COUNT 13
`define CRF_BANK_REGS 7
`define CRF_BANK_COUNT 2

// Bit positions inside the flag register.
`define CRF_FLG_C 0
`define CRF_FLG_D 1
`define CRF_FLG_Z 2
`define CRF_FLG_S 3
`define CRF_FLG_B 4
`define CRF_FLG_O 5
`define CRF_FLG_I 6
`define CRF_FLG_U 7
`define CRF_FLG_IPL_LSB 8
`define CRF_FLG_IPL_MSB 10

// Reset values.
`define CRF_RST_WORD 16'h0000
`define CRF_RST_ADDR 20'h00000
`define CRF_RST_FLAGS 11'h000
`define CRF_RST_LONG 32'h00000000

`endif

// ===== include/crf_pkg.sv
`include "crf_map.svh"

package crf_pkg;

    // Register selector; codes 0 to 6 are the bank-switched entries.
    typedef enum logic [3:0] {
        SEL_DATA_REG_ZERO    = 4'b0000,
        SEL_DATA_REG_ONE     = 4'b0001,
        SEL_DATA_REG_TWO     = 4'b0010,
        SEL_DATA_REG_THREE   = 4'b0011,
        SEL_ADDR_REG_ZERO    = 4'b0100,
        SEL_ADDR_REG_ONE     = 4'b0101,
        SEL_FRAME_BASE       = 4'b0110,
        SEL_STATIC_BASE      = 4'b0111,
        SEL_USER_STACK_PTR   = 4'b1000,
        SEL_IRQ_STACK_PTR    = 4'b1001,
        SEL_ACTIVE_STACK_PTR = 4'b1010,
        SEL_VECTOR_TABLE     = 4'b1011,
        SEL_CPU_FLAGS        = 4'b1100,
        SEL_NEXT_INSTR_PTR   = 4'b1101
    } crf_sel_e;

    // Access size: low byte, high byte, word, or 32-bit pair.
    typedef enum logic [1:0] {
        SZ_LOW  = 2'b00,
        SZ_HIGH = 2'b01,
        SZ_WORD = 2'b10,
        SZ_PAIR = 2'b11
    } crf_size_e;

    // Operand width of an ALU result.
    typedef enum logic [1:0] {
        AW_BYTE = 2'b00,
        AW_WORD = 2'b01,
        AW_LONG = 2'b10
    } crf_width_e;

    // One write request from the execution unit.
    typedef struct packed {
        logic en;
        crf_sel_e sel;
        crf_size_e size;
        logic [`CRF_LONG_W-1:0] data;
    } crf_wr_s;

    // Flag update from the ALU.
    typedef struct packed {
        logic upd;
        crf_width_e width;
        logic [`CRF_LONG_W-1:0] result;
        logic carry;
        logic ovf;
    } crf_alu_s;

    // Registered view of the state that the core uses every cycle.
    typedef struct packed {
        logic [`CRF_ADDR_W-1:0] next_instr_pointer;
        logic [`CRF_ADDR_W-1:0] vector_table_base;
        logic [`CRF_WORD_W-1:0] active_stack_ptr;
        logic [`CRF_WORD_W-1:0] static_base;
        logic [`CRF_WORD_W-1:0] frame_base;
        logic [`CRF_FLAG_W-1:0] cpu_flags;
    } crf_state_s;

endpackage

// ===== rtl/crf_flag_eval.sv
`timescale 1ns/1ps
`default_nettype none

`include "crf_map.svh"

module crf_flag_eval
    import crf_pkg::*;
(
    input wire logic [`CRF_LONG_W-1:0] result_i,
    input wire crf_width_e width_i,
    output logic zero_o,
    output logic neg_o
);

    // Zero and sign are judged on the operand width only.
    always_comb
    begin
        case (width_i)
            AW_BYTE:
            begin
                zero_o = (result_i[7:0] == 8'h00);
                neg_o = result_i[7];
            end
            AW_WORD:
            begin
                zero_o = (result_i[15:0] == 16'h0000);
                neg_o = result_i[15];
            end
            default:
            begin
                zero_o = (result_i == `CRF_RST_LONG);
                neg_o = result_i[31];
            end
        endcase
    end

endmodule

`default_nettype wire

// ===== rtl/crf_core.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Thirteen core registers, counting a single bank of seven switched ones.
// - Four data, two address and frame base form a bank; two banks.
// - Data zero and one are 16-bit, with independent high and low bytes.
// - Data two with zero, and three with one, form 32-bit operands.
// - Address registers are 16-bit and pair into one 32-bit operand.
// - Frame base is 16 bits and bases frame-relative addressing.
// - Vector table base is 20 bits and holds the vector table start.
// - Program counter is 20 bits and holds the next instruction address.
// - Two 16-bit stack pointers; stack-select flag picks the active one.
// - Static base is 16 bits and bases static-relative addressing.
// - Flag register is 11 bits and shows the CPU state.
// - Carry flag captures carry, borrow or shifted-out bit of each ALU operation; an explicit flag write in the same cycle wins over the ALU.
// - Zero flag is one for a zero result, else zero.
// - Sign flag is one for a negative result, else zero.
// - Bank-select flag routes switched accesses to bank zero or bank one.
// - Overflow flag is one on signed overflow, else zero.

`include "crf_map.svh"

module crf_core
    import crf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire crf_wr_s wr_i,
    input wire crf_sel_e rd_sel_i,
    input wire crf_size_e rd_size_i,
    input wire crf_alu_s alu_i,
    input wire logic pc_we_i,
    input wire logic [`CRF_ADDR_W-1:0] pc_data_i,
    output logic [`CRF_LONG_W-1:0] rd_data_o,
    output var crf_state_s state_o
);

    // Two banks of seven switched registers, addressed by bank and entry.
    logic [`CRF_WORD_W-1:0] bank_r [`CRF_BANK_COUNT][`CRF_BANK_REGS];
    logic [`CRF_WORD_W-1:0] cur [`CRF_BANK_REGS];
    logic [`CRF_WORD_W-1:0] static_base_r;
    logic [`CRF_WORD_W-1:0] user_stack_ptr_r;
    logic [`CRF_WORD_W-1:0] irq_stack_ptr_r;
    logic [`CRF_ADDR_W-1:0] vector_table_base_r;
    logic [`CRF_ADDR_W-1:0] next_instr_pointer_r;
    logic [`CRF_FLAG_W-1:0] cpu_flags_r;
    logic [`CRF_LONG_W-1:0] rd_nxt;
    logic bank_sel;
    logic stack_sel;
    logic res_zero;
    logic res_neg;
    logic wr_word;
    logic wr_wide;
    logic flag_wr;
    logic [`CRF_WORD_W-1:0] active_sp;

    // Bank and stack selection come from the stored flags.
    assign bank_sel = cpu_flags_r[`CRF_FLG_B];
    assign stack_sel = cpu_flags_r[`CRF_FLG_U];
    assign active_sp = stack_sel ? irq_stack_ptr_r : user_stack_ptr_r;

    // Word writes reach 16-bit registers; pair writes also reach 20-bit ones.
    assign wr_word = wr_i.en && (wr_i.size == SZ_WORD);
    assign wr_wide = wr_i.en && ((wr_i.size == SZ_WORD) || (wr_i.size == SZ_PAIR));
    assign flag_wr = wr_word && (wr_i.sel == SEL_CPU_FLAGS);

    // Zero and sign of the current ALU result.
    crf_flag_eval u_flag_eval (
        .result_i(alu_i.result),
        .width_i(alu_i.width),
        .zero_o(res_zero),
        .neg_o(res_neg)
    );

    // Per entry of the bank: decode the write, then store it in the selected bank only.
    genvar gk;
    genvar gb;
    generate
        for (gk = 0; gk < `CRF_BANK_REGS; gk++)
        begin : g_ent
            // Pair members: entries 2, 3 and 5 are the upper halves of 0, 1 and 4.
            localparam bit IS_HI = (gk == 2) || (gk == 3) || (gk == 5);
            localparam int LO_IDX = (gk == 5) ? 4 : ((gk >= 2) ? gk - 2 : gk);
            localparam bit BYTE_OK = (gk < 2);
            localparam bit PAIR_BASE = (gk == 0) || (gk == 1) || (gk == 4);
            logic en;
            logic [`CRF_WORD_W-1:0] val;

            assign cur[gk] = bank_r[bank_sel][gk];

            always_comb
            begin
                en = 1'b0;
                val = cur[gk];
                if (wr_i.en && (wr_i.sel == 4'(gk)))
                begin
                    if (wr_i.size == SZ_WORD)
                    begin
                        en = 1'b1;
                        val = wr_i.data[15:0];
                    end
                    else if ((wr_i.size == SZ_LOW) && BYTE_OK)
                    begin
                        en = 1'b1;
                        val = {cur[gk][15:8], wr_i.data[7:0]};
                    end
                    else if ((wr_i.size == SZ_HIGH) && BYTE_OK)
                    begin
                        en = 1'b1;
                        val = {wr_i.data[7:0], cur[gk][7:0]};
                    end
                    else if ((wr_i.size == SZ_PAIR) && PAIR_BASE)
                    begin
                        en = 1'b1;
                        val = wr_i.data[15:0];
                    end
                end
                else if (wr_i.en && (wr_i.size == SZ_PAIR) && IS_HI
                         && (wr_i.sel == 4'(LO_IDX)))
                begin
                    en = 1'b1;
                    val = wr_i.data[31:16];
                end
            end

            for (gb = 0; gb < `CRF_BANK_COUNT; gb++)
            begin : g_bank
                // Only the selected bank is written; the other keeps its values.
                always_ff @(posedge clk_i)
                begin
                    if (rst_i)
                        bank_r[gb][gk] <= `CRF_RST_WORD;
                    else if (en && (bank_sel == 1'(gb)))
                        bank_r[gb][gk] <= val;
                end
            end
        end
    endgenerate

    // Static base register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            static_base_r <= `CRF_RST_WORD;
        else if (wr_word && (wr_i.sel == SEL_STATIC_BASE))
            static_base_r <= wr_i.data[15:0];
    end

    // User stack pointer, written directly or as the active pointer.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            user_stack_ptr_r <= `CRF_RST_WORD;
        else if (wr_word && ((wr_i.sel == SEL_USER_STACK_PTR)
                 || ((wr_i.sel == SEL_ACTIVE_STACK_PTR) && !stack_sel)))
            user_stack_ptr_r <= wr_i.data[15:0];
    end

    // Interrupt stack pointer, written directly or as the active pointer.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_stack_ptr_r <= `CRF_RST_WORD;
        else if (wr_word && ((wr_i.sel == SEL_IRQ_STACK_PTR)
                 || ((wr_i.sel == SEL_ACTIVE_STACK_PTR) && stack_sel)))
            irq_stack_ptr_r <= wr_i.data[15:0];
    end

    // Vector table base takes twenty bits of a word or pair write.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            vector_table_base_r <= `CRF_RST_ADDR;
        else if (wr_wide && (wr_i.sel == SEL_VECTOR_TABLE))
            vector_table_base_r <= wr_i.data[19:0];
    end

    // Program counter: the dedicated load port wins over a register write.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            next_instr_pointer_r <= `CRF_RST_ADDR;
        else if (pc_we_i)
            next_instr_pointer_r <= pc_data_i;
        else if (wr_wide && (wr_i.sel == SEL_NEXT_INSTR_PTR))
            next_instr_pointer_r <= wr_i.data[19:0];
    end

    // Flags: an explicit write wins; otherwise the ALU updates C, Z, S and O.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cpu_flags_r <= `CRF_RST_FLAGS;
        else if (flag_wr)
            cpu_flags_r <= wr_i.data[10:0];
        else if (alu_i.upd)
        begin
            cpu_flags_r[`CRF_FLG_C] <= alu_i.carry;
            cpu_flags_r[`CRF_FLG_Z] <= res_zero;
            cpu_flags_r[`CRF_FLG_S] <= res_neg;
            cpu_flags_r[`CRF_FLG_O] <= alu_i.ovf;
        end
    end

    // Read multiplexer with byte, word and pair views.
    always_comb
    begin
        rd_nxt = `CRF_RST_LONG;
        if (rd_sel_i <= SEL_FRAME_BASE)
        begin
            if ((rd_size_i == SZ_LOW) && (rd_sel_i <= SEL_DATA_REG_ONE))
                rd_nxt = {24'h000000, cur[rd_sel_i[2:0]][7:0]};
            else if ((rd_size_i == SZ_HIGH) && (rd_sel_i <= SEL_DATA_REG_ONE))
                rd_nxt = {24'h000000, cur[rd_sel_i[2:0]][15:8]};
            else if ((rd_size_i == SZ_PAIR) && (rd_sel_i <= SEL_DATA_REG_ONE))
                rd_nxt = {cur[rd_sel_i[2:0] + 3'h2], cur[rd_sel_i[2:0]]};
            else if ((rd_size_i == SZ_PAIR) && (rd_sel_i == SEL_ADDR_REG_ZERO))
                rd_nxt = {cur[5], cur[4]};
            else if (rd_size_i == SZ_WORD)
                rd_nxt = {16'h0000, cur[rd_sel_i[2:0]]};
        end
        else if (rd_sel_i == SEL_STATIC_BASE)
            rd_nxt = {16'h0000, static_base_r};
        else if (rd_sel_i == SEL_USER_STACK_PTR)
            rd_nxt = {16'h0000, user_stack_ptr_r};
        else if (rd_sel_i == SEL_IRQ_STACK_PTR)
            rd_nxt = {16'h0000, irq_stack_ptr_r};
        else if (rd_sel_i == SEL_ACTIVE_STACK_PTR)
            rd_nxt = {16'h0000, active_sp};
        else if (rd_sel_i == SEL_VECTOR_TABLE)
            rd_nxt = {12'h000, vector_table_base_r};
        else if (rd_sel_i == SEL_CPU_FLAGS)
            rd_nxt = {21'h00000, cpu_flags_r};
        else if (rd_sel_i == SEL_NEXT_INSTR_PTR)
            rd_nxt = {12'h000, next_instr_pointer_r};
    end

    // Read data is registered, one cycle after the select.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rd_data_o <= `CRF_RST_LONG;
        else
            rd_data_o <= rd_nxt;
    end

    // Registered state view for the address and control logic of the core.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_o <= '0;
        else
        begin
            state_o.next_instr_pointer <= next_instr_pointer_r;
            state_o.vector_table_base <= vector_table_base_r;
            state_o.active_stack_ptr <= active_sp;
            state_o.static_base <= static_base_r;
            state_o.frame_base <= cur[6];
            state_o.cpu_flags <= cpu_flags_r;
        end
    end

    // Checks run on the core clock and rest during reset.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_alu_only;
        alu_i.upd && !flag_wr;
    endsequence

    sequence s_bank0_word_write;
        wr_i.en && (wr_i.size == SZ_WORD) && (wr_i.sel == SEL_DATA_REG_ZERO) && !bank_sel;
    endsequence

    sequence s_bank1_word_write;
        wr_i.en && (wr_i.size == SZ_WORD) && (wr_i.sel == SEL_DATA_REG_ZERO) && bank_sel;
    endsequence

    zero_flag_a: assert property (s_alu_only |=> cpu_flags_r[`CRF_FLG_Z] == $past(res_zero))
        else $error("Zero flag does not follow the ALU result.");

    sign_flag_a: assert property (s_alu_only |=> cpu_flags_r[`CRF_FLG_S] == $past(res_neg))
        else $error("Sign flag does not follow the ALU result.");

    carry_flag_a: assert property (s_alu_only |=> cpu_flags_r[`CRF_FLG_C] == $past(alu_i.carry))
        else $error("Carry flag does not capture the ALU carry.");

    overflow_flag_a: assert property (s_alu_only |=> cpu_flags_r[`CRF_FLG_O] == $past(alu_i.ovf))
        else $error("Overflow flag does not capture the ALU overflow.");

    bank_hold_a: assert property (s_bank0_word_write |=> $stable(bank_r[1][0]))
        else $error("Unselected bank changed on a write.");

    bank_route_a: assert property (s_bank0_word_write |=> bank_r[0][0] == $past(wr_i.data[15:0]))
        else $error("Write did not reach the selected bank.");

    bank_one_hold_a: assert property (s_bank1_word_write |=> $stable(bank_r[0][0]))
        else $error("Bank zero changed on a bank one write.");

    bank_one_route_a: assert property (s_bank1_word_write
        |=> bank_r[1][0] == $past(wr_i.data[15:0]))
        else $error("Write did not reach bank one.");

    byte_high_a: assert property (wr_i.en && (wr_i.size == SZ_HIGH)
        && (wr_i.sel == SEL_DATA_REG_ONE) && !pc_we_i |=> $stable(cur[1][7:0]))
        else $error("High byte write disturbed the low byte.");

    pair_read_a: assert property ((rd_sel_i == SEL_DATA_REG_ZERO)
        && (rd_size_i == SZ_PAIR) |=> rd_data_o == {$past(cur[2]), $past(cur[0])})
        else $error("Data pair read has the wrong half order.");

    addr_pair_a: assert property ((rd_sel_i == SEL_ADDR_REG_ZERO)
        && (rd_size_i == SZ_PAIR) |=> rd_data_o == {$past(cur[5]), $past(cur[4])})
        else $error("Address pair read has the wrong half order.");

    stack_view_a: assert property (##1 1'b1 |-> ##1 state_o.active_stack_ptr
        == (cpu_flags_r[`CRF_FLG_U] ? $past(irq_stack_ptr_r) : $past(user_stack_ptr_r))
        || $changed(cpu_flags_r[`CRF_FLG_U]))
        else $error("Active stack pointer does not follow the stack-select flag.");

    pc_load_a: assert property (pc_we_i |=> next_instr_pointer_r == $past(pc_data_i)
        ##1 state_o.next_instr_pointer == $past(pc_data_i, 2))
        else $error("Program counter load was lost.");

    flag_write_a: assert property (flag_wr |=> cpu_flags_r == $past(wr_i.data[10:0]))
        else $error("Flag register write was lost.");

    vector_base_a: assert property (wr_wide && (wr_i.sel == SEL_VECTOR_TABLE)
        |=> vector_table_base_r == $past(wr_i.data[19:0]))
        else $error("Vector table base write was lost.");

    static_base_a: assert property (wr_word && (wr_i.sel == SEL_STATIC_BASE)
        |=> static_base_r == $past(wr_i.data[15:0]))
        else $error("Static base write was lost.");

    frame_view_a: assert property (1'b1 |=> state_o.frame_base == $past(cur[6]))
        else $error("Frame base view does not follow the selected bank.");

endmodule

`default_nettype wire

// ===== verification/crf_exec_model.sv
`timescale 1ns/1ps
`default_nettype none

`include "crf_map.svh"

// Stand-in for the execution unit: issues one request per call, one edge long.
module crf_exec_model
    import crf_pkg::*;
(
    input wire logic clk_i,
    output var crf_wr_s wr_o,
    output var crf_alu_s alu_o,
    output logic pc_we_o,
    output logic [`CRF_ADDR_W-1:0] pc_data_o
);

    // Requests start idle, with busy-looking data so that stale values cannot match.
    initial
    begin
        wr_o = '{en: 1'b0, sel: SEL_DATA_REG_ZERO, size: SZ_WORD, data: 32'hA5A5A5A5};
        alu_o = '{upd: 1'b0, width: AW_WORD, result: 32'h5A5A5A5A, carry: 1'b0, ovf: 1'b0};
        pc_we_o = 1'b0;
        pc_data_o = 20'hA5A5A;
    end

    // Presents one write for a single edge, then releases it with inverted data.
    task automatic write(input crf_sel_e sel, input crf_size_e size, input logic [31:0] data);
        @(posedge clk_i);
        wr_o <= '{en: 1'b1, sel: sel, size: size, data: data};
        @(posedge clk_i);
        wr_o.en <= 1'b0;
        wr_o.data <= ~data;
    endtask

    // Writes the flag register; the debug bit is always sent as zero.
    task automatic flags(input logic [10:0] v);
        write(SEL_CPU_FLAGS, SZ_WORD, {21'h00000, v & 11'h7FD});
    endtask

    // Presents one ALU result for a single edge.
    task automatic alu(input crf_width_e w, input logic [31:0] r, input logic c, input logic o);
        @(posedge clk_i);
        alu_o <= '{upd: 1'b1, width: w, result: r, carry: c, ovf: o};
        @(posedge clk_i);
        alu_o.upd <= 1'b0;
        alu_o.result <= ~r;
    endtask

    // Loads the program counter for a single edge.
    task automatic pc(input logic [19:0] v);
        @(posedge clk_i);
        pc_we_o <= 1'b1;
        pc_data_o <= v;
        @(posedge clk_i);
        pc_we_o <= 1'b0;
        pc_data_o <= ~v;
    endtask

endmodule

`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

`include "crf_map.svh"

module tb
    import crf_pkg::*;
;

    logic clk_i;
    logic rst_i;
    crf_wr_s wr;
    crf_alu_s alu;
    logic pc_we;
    logic [19:0] pc_data;
    crf_sel_e rd_sel;
    crf_size_e rd_size;
    logic [31:0] rd_data;
    crf_state_s state;
    int fail_count;
    int samples_checked;

    crf_exec_model exec (.clk_i(clk_i), .wr_o(wr), .alu_o(alu), .pc_we_o(pc_we),
        .pc_data_o(pc_data));

    crf_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr), .rd_sel_i(rd_sel),
        .rd_size_i(rd_size), .alu_i(alu), .pc_we_i(pc_we), .pc_data_i(pc_data),
        .rd_data_o(rd_data), .state_o(state));

    // Free-running core clock at 100 MHz.
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // Selects a register and compares the registered read data one cycle later.
    task automatic rd(input crf_sel_e sel, input crf_size_e size, input logic [31:0] exp);
        @(posedge clk_i);
        rd_sel <= sel;
        rd_size <= size;
        @(posedge clk_i);
        #1;
        chk(sel.name(), exp, rd_data);
    endtask

    // Lets the registered state view catch up with the stored registers.
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    // Byte halves of the first two data registers are written separately.
    task automatic t_bytes();
        exec.write(SEL_DATA_REG_ZERO, SZ_WORD, 32'h00001234);
        exec.write(SEL_DATA_REG_ZERO, SZ_HIGH, 32'h000000AB);
        rd(SEL_DATA_REG_ZERO, SZ_WORD, 32'h0000AB34);
        rd(SEL_DATA_REG_ZERO, SZ_LOW, 32'h00000034);
        rd(SEL_DATA_REG_ZERO, SZ_HIGH, 32'h000000AB);
        exec.write(SEL_DATA_REG_ONE, SZ_WORD, 32'h00005678);
        exec.write(SEL_DATA_REG_ONE, SZ_LOW, 32'h000000C3);
        rd(SEL_DATA_REG_ONE, SZ_WORD, 32'h000056C3);
        exec.write(SEL_DATA_REG_ONE, SZ_HIGH, 32'h0000009A);
        rd(SEL_DATA_REG_ONE, SZ_WORD, 32'h00009AC3);
    endtask

    // Each pair splits into its two words, upper word in the second register.
    task automatic t_pairs();
        crf_sel_e lo[3];
        crf_sel_e hi[3];
        logic [31:0] v[3];
        lo = '{SEL_DATA_REG_ZERO, SEL_DATA_REG_ONE, SEL_ADDR_REG_ZERO};
        hi = '{SEL_DATA_REG_TWO, SEL_DATA_REG_THREE, SEL_ADDR_REG_ONE};
        v = '{32'h89ABCDEF, 32'h13572468, 32'h0F1E2D3C};
        for (int i = 0; i < 3; i++)
        begin
            exec.write(lo[i], SZ_PAIR, v[i]);
            rd(lo[i], SZ_WORD, {16'h0000, v[i][15:0]});
            rd(hi[i], SZ_WORD, {16'h0000, v[i][31:16]});
            rd(lo[i], SZ_PAIR, v[i]);
        end
        exec.write(SEL_ADDR_REG_ZERO, SZ_HIGH, 32'h000000FF);
        rd(SEL_ADDR_REG_ZERO, SZ_WORD, 32'h00002D3C);
    endtask

    // The second bank is used and the first keeps its values meanwhile.
    task automatic t_banks();
        exec.flags(11'h010);
        exec.write(SEL_DATA_REG_ZERO, SZ_WORD, 32'h00005555);
        exec.write(SEL_FRAME_BASE, SZ_WORD, 32'h00007777);
        rd(SEL_DATA_REG_ZERO, SZ_WORD, 32'h00005555);
        settle();
        chk("frame_base", 32'h00007777, {16'h0000, state.frame_base});
        exec.flags(11'h000);
        rd(SEL_DATA_REG_ZERO, SZ_WORD, 32'h0000CDEF);
        rd(SEL_DATA_REG_TWO, SZ_WORD, 32'h000089AB);
        settle();
        chk("frame_base", 32'h00000000, {16'h0000, state.frame_base});
        exec.flags(11'h010);
        rd(SEL_DATA_REG_ZERO, SZ_WORD, 32'h00005555);
        exec.flags(11'h000);
    endtask

    // Stack-select flag chooses the active stack pointer; all flag bits but D, which the model sends as zero, read back as written.
    task automatic t_stack();
        exec.write(SEL_USER_STACK_PTR, SZ_WORD, 32'h00001111);
        exec.write(SEL_IRQ_STACK_PTR, SZ_WORD, 32'h00002222);
        settle();
        chk("active_sp", 32'h00001111, {16'h0000, state.active_stack_ptr});
        exec.flags(11'h7FF);
        rd(SEL_CPU_FLAGS, SZ_WORD, 32'h000007FD);
        settle();
        chk("active_sp", 32'h00002222, {16'h0000, state.active_stack_ptr});
        chk("cpu_flags", 32'h000007FD, {21'h00000, state.cpu_flags});
        rd(SEL_ACTIVE_STACK_PTR, SZ_WORD, 32'h00002222);
        exec.write(SEL_ACTIVE_STACK_PTR, SZ_WORD, 32'h00003333);
        rd(SEL_IRQ_STACK_PTR, SZ_WORD, 32'h00003333);
        rd(SEL_USER_STACK_PTR, SZ_WORD, 32'h00001111);
        exec.flags(11'h000);
    endtask

    // ALU results of byte, word and long width together set carry, zero, sign and overflow.
    task automatic t_alu();
        crf_width_e w[5];
        logic [31:0] r[5];
        logic [3:0] co[5];
        logic [31:0] f[5];
        w = '{AW_BYTE, AW_WORD, AW_LONG, AW_WORD, AW_BYTE};
        r = '{32'h00000100, 32'h00008000, 32'h80000000, 32'h00010000, 32'h0000007F};
        co = '{4'h2, 4'h1, 4'h3, 4'h0, 4'h0};
        f = '{32'h005, 32'h028, 32'h029, 32'h004, 32'h000};
        for (int i = 0; i < 5; i++)
        begin
            exec.alu(w[i], r[i], co[i][1], co[i][0]);
            rd(SEL_CPU_FLAGS, SZ_WORD, f[i]);
        end
    endtask

    // Program counter, vector base and static base hold their full widths.
    task automatic t_ptrs();
        exec.pc(20'hABCDE);
        exec.write(SEL_VECTOR_TABLE, SZ_WORD, 32'h0FFF1234);
        exec.write(SEL_STATIC_BASE, SZ_WORD, 32'h00002468);
        settle();
        chk("next_instr", 32'h000ABCDE, {12'h000, state.next_instr_pointer});
        chk("vector_base", 32'h000F1234, {12'h000, state.vector_table_base});
        chk("static_base", 32'h00002468, {16'h0000, state.static_base});
        rd(SEL_VECTOR_TABLE, SZ_WORD, 32'h000F1234);
        rd(SEL_STATIC_BASE, SZ_WORD, 32'h00002468);
        exec.write(SEL_NEXT_INSTR_PTR, SZ_PAIR, 32'hFFF12345);
        rd(SEL_NEXT_INSTR_PTR, SZ_WORD, 32'h00012345);
    endtask

    // A reset in mid-run clears the registers that earlier scenarios filled.
    task automatic t_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SEL_STATIC_BASE, SZ_WORD, 32'h00000000);
        chk("reset_flags", 32'h00000000, {21'h00000, state.cpu_flags});
        chk("reset_pc_mid", 32'h00000000, {12'h000, state.next_instr_pointer});
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial
    begin
        fail_count = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        // The first read falls inside reset, so it must see cleared read data.
        rd(SEL_CPU_FLAGS, SZ_WORD, 32'h00000000);
        repeat (14) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("reset_pc", 32'h00000000, {12'h000, state.next_instr_pointer});
        t_bytes();
        t_pairs();
        t_banks();
        t_stack();
        t_alu();
        t_ptrs();
        t_reset();
        test_done();
    end

    // Cuts a hang short well beyond the some 160 cycles the scenarios need.
    initial
    begin
        #200000;
        fail_count++;
        test_done();
    end

endmodule

`default_nettype wire
